//--- hw/adcr_defs.vh
// register offsets, field positions, reset values and codes for adcr block
// assumes inclusion by bare name from the design files
`ifndef ADCR_DEFS_VH
`define ADCR_DEFS_VH
// register word indices (byte address = 4 * index)
`define ADCR_IDX_MODE_TRIG    4'h3
`define ADCR_IDX_RES_LOW      4'h4
`define ADCR_IDX_RES_HIGH     4'h5
`define ADCR_IDX_CONV_CTRL_A  4'h6
`define ADCR_IDX_CHAN_SEL     4'h7
`define ADCR_IDX_PIN_DISABLE  4'h8
`define ADCR_IDX_STATUS       4'h9
// mode/trigger register fields
`define ADCR_BIT_BIPOLAR      7
`define ADCR_BIT_CMP_MUX      6
`define ADCR_BIT_POL_REV      5
`define ADCR_TRIG_HI          2
`define ADCR_TRIG_LO          0
`define ADCR_MODE_TRIG_MASK   8'he7
// conversion control a fields
`define ADCR_BIT_ENABLE       7
`define ADCR_BIT_START        6
`define ADCR_BIT_AUTO         5
`define ADCR_BIT_DONE         4
`define ADCR_BIT_IRQ_EN       3
`define ADCR_PRE_HI           2
`define ADCR_PRE_LO           0
// channel select register fields
`define ADCR_BIT_LEFT_ADJ     5
`define ADCR_CHAN_HI          3
`define ADCR_CHAN_LO          0
`define ADCR_CHAN_SEL_MASK    8'h2f
// pin disable field
`define ADCR_PIN_HI           5
`define ADCR_PIN_LO           2
`define ADCR_PIN_MASK         8'h3c
// reset values
`define ADCR_RST_BYTE         8'h00
`define ADCR_RST_RESULT       10'h000
// trigger source codes
`define ADCR_SRC_FREE         3'h0
`define ADCR_SRC_COMP         3'h1
`define ADCR_SRC_EXT0         3'h2
`define ADCR_SRC_T0_CMPA      3'h3
`define ADCR_SRC_T0_OVF       3'h4
`define ADCR_SRC_T0_CMPB      3'h5
`define ADCR_SRC_PIN_CHG      3'h6
`endif

//--- hw/adcr_trig_sel.v
// trigger source selector and rising edge detector
// assumes flag inputs are already synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
`include "adcr_defs.vh"
module adcr_trig_sel (
  input  wire       core_clk,    // system clock
  input  wire       rst,         // sync reset, active high
  input  wire [2:0] trigSel,     // trigger source code
  input  wire [6:0] srcFlags,    // flags indexed by code, bit0 unused
  output wire       trigEdge     // one-cycle rising edge pulse
);
  reg  selNow;                   // currently selected flag level
  reg  selPrev;                  // last cycle's selected level
  // decode source code to the chosen flag
  always @* begin
    case (trigSel)
      `ADCR_SRC_FREE:    selNow = 1'b0;
      `ADCR_SRC_COMP:    selNow = srcFlags[1];
      `ADCR_SRC_EXT0:    selNow = srcFlags[2];
      `ADCR_SRC_T0_CMPA: selNow = srcFlags[3];
      `ADCR_SRC_T0_OVF:  selNow = srcFlags[4];
      `ADCR_SRC_T0_CMPB: selNow = srcFlags[5];
      `ADCR_SRC_PIN_CHG: selNow = srcFlags[6];
      default:           selNow = 1'b0;          // unused code
    endcase
  end
  // remember selected level; selection switch makes an edge too
  always @(posedge core_clk) begin
    if (rst) begin
      selPrev <= 1'b0;
    end else begin
      selPrev <= selNow;
    end
  end
  assign trigEdge = selNow & ~selPrev;
endmodule // adcr_trig_sel
`default_nettype wire

//--- hw/adcr_result_fmt.v
// result byte formatter, right or left adjusted
// assumes a 10-bit latched result; pure combinational
`timescale 1ns/10ps
`default_nettype none
module adcr_result_fmt (
  input  wire [9:0] result,      // latched conversion result
  input  wire       leftAdj,     // left adjust select
  output reg  [7:0] lowByte,     // low result byte view
  output reg  [7:0] highByte     // high result byte view
);
  // presentation follows the select at once
  always @* begin
    if (leftAdj) begin
      highByte = result[9:2];
      lowByte  = {result[1:0], 6'h00};
    end else begin
      highByte = {6'h00, result[9:8]};
      lowByte  = result[7:0];
    end
  end
endmodule // adcr_result_fmt
`default_nettype wire

//--- hw/adcr_top.v
// register side of the converter: result bytes, lock, modes, triggers
// assumes a classic wishbone master on core_clk and a converter core that
// pulses convDone with convData; pin inputs arrive unsynchronised
//
// Notes on behaviour
// - finished conversion loads result byte pair
// - right adjust: bits 9:8 high, 7:0 low
// - left adjust: bits 9:2 high, 1:0 low top
// - low read locks pair until high read
// - mode bit 7 clear means unipolar
// - mode bit set gives two's complement bipolar
// - bit 5 swaps differential input roles
// - mode register bits 4:3 read zero
// - trigger source only matters with auto trigger
// - auto trigger starts on selected flag rise
// - switching to set source counts as edge
// - switching to free running never triggers
// - trigger source code decode table
// - pin disable bits gate buffers, read zero
// - left adjust change shows at once
// - done flag set at end, cleared by one
`timescale 1ns/10ps
`default_nettype none
`include "adcr_defs.vh"
module adcr_top (
  input  wire        core_clk,     // system clock, 50 MHz
  input  wire        rst,          // sync reset, active high
  // wishbone slave
  input  wire        wb_cyc_i,     // bus cycle
  input  wire        wb_stb_i,     // strobe
  input  wire        wb_we_i,      // write enable
  input  wire [5:0]  wb_adr_i,     // byte address
  input  wire [3:0]  wb_sel_i,     // byte lanes
  input  wire [31:0] wb_dat_i,     // write data
  output reg  [31:0] wb_dat_o,     // read data
  output reg         wb_ack_o,     // acknowledge
  // converter core side
  output wire        convStart,    // one-cycle start pulse to core
  input  wire        convDone,     // one-cycle completion pulse
  input  wire [9:0]  convData,     // core result at completion
  output wire        convEnable,   // converter enable level
  output wire        bipolarMode,  // bipolar conversion select
  output wire        polarityRev,  // swap differential inputs
  output wire        compMuxEn,    // comparator mux enable
  output wire [3:0]  channelSel,   // channel select bits
  output wire [2:0]  prescaleSel,  // prescaler select
  output wire        convDoneIrq,  // done flag and enable (level)
  input  wire        irqVectorAck, // vector entry clears done flag
  // trigger flags from other peripherals (same clock)
  input  wire        flagComp,     // analog comparator flag
  input  wire        flagExt0,     // external interrupt 0 flag
  input  wire        flagT0CmpA,   // timer 0 compare a flag
  input  wire        flagT0Ovf,    // timer 0 overflow flag
  input  wire        flagT0CmpB,   // timer 0 compare b flag
  input  wire        flagPinChg,   // pin change flag
  // analog pin digital buffers
  input  wire [3:0]  pinRaw,       // raw pin levels, async
  output wire [3:0]  pinBufOff,    // buffer disable per pin
  output wire [3:0]  pinValue      // synchronised, gated pin value
);
  // software registers
  reg  [7:0] modeTrig;             // mode/trigger control
  reg  [7:0] ctrlA;                // enable, start, auto, done, irq, pre
  reg  [7:0] chanSel;              // left adjust and channel bits
  reg  [7:0] pinDisable;           // pin buffer disable bits
  reg  [9:0] result;               // latched result
  reg        lowReadLock;          // pair frozen after low read
  reg  [9:0] heldData;             // completion seen during lock
  reg        heldValid;            // a held completion waits
  reg        busy;                 // conversion in progress
  reg  [3:0] pinSync1;             // pin synchroniser stage 1
  reg  [3:0] pinSync2;             // pin synchroniser stage 2
  // bus decode
  wire       busReq;               // valid request this cycle
  wire       wrLane0;              // write to low byte lane
  wire [3:0] regIdx;               // word index
  reg  [7:0] next_rdByte;          // read byte for the next ack
  wire [7:0] lowByte;              // formatted low byte
  wire [7:0] highByte;             // formatted high byte
  wire       trigEdge;             // selected trigger rising edge
  wire       autoStart;            // start from auto trigger
  wire       swStart;              // start from software write
  wire       freeRestart;          // free running re-start
  wire       doneSet;              // done flag setting event
  wire       doneClr;              // done flag clear event
  wire       rdLow;                // low byte read accepted
  wire       rdHigh;               // high byte read accepted
  wire       wrCtrlA;              // write to control a

  // decode write-enable per register index
  function isWrite;
    input [3:0] idx;
    input [3:0] want;
    input       req;
    input       we;
    input       lane;
    begin
      isWrite = req & we & lane & (idx == want);
    end
  endfunction

  // decode an accepted read of one register index
  function isRead;
    input [3:0] idx;
    input [3:0] want;
    input       req;
    input       we;
    begin
      isRead = req & ~we & (idx == want);
    end
  endfunction

  // ack masks the request, so a held request is taken only once
  assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrLane0 = wb_sel_i[0];
  assign regIdx  = wb_adr_i[5:2];
  // low read freezes the result pair, high read releases it
  assign rdLow   = isRead(regIdx, `ADCR_IDX_RES_LOW, busReq, wb_we_i);
  assign rdHigh  = isRead(regIdx, `ADCR_IDX_RES_HIGH, busReq, wb_we_i);
  assign wrCtrlA = isWrite(regIdx, `ADCR_IDX_CONV_CTRL_A, busReq,
                           wb_we_i, wrLane0);

  // result formatter, follows left adjust immediately
  adcr_result_fmt u_fmt (
    .result   (result),
    .leftAdj  (chanSel[`ADCR_BIT_LEFT_ADJ]),
    .lowByte  (lowByte),
    .highByte (highByte)
  );

  // trigger selection; bit0 unused, free running has no edge
  adcr_trig_sel u_trig (
    .core_clk (core_clk),
    .rst      (rst),
    .trigSel  (modeTrig[`ADCR_TRIG_HI:`ADCR_TRIG_LO]),
    .srcFlags ({flagPinChg, flagT0CmpB, flagT0Ovf, flagT0CmpA,
                flagExt0, flagComp, 1'b0}),
    .trigEdge (trigEdge)
  );

  // start sources: software bit, gated auto edge, free running chain
  // a start while busy is dropped; a restart needs no idle cycle
  assign swStart     = wrCtrlA & wb_dat_i[`ADCR_BIT_START] &
                       wb_dat_i[`ADCR_BIT_ENABLE];
  assign autoStart   = ctrlA[`ADCR_BIT_ENABLE] & ctrlA[`ADCR_BIT_AUTO] &
                       trigEdge;
  assign freeRestart = convDone & busy & ctrlA[`ADCR_BIT_ENABLE] &
                       ctrlA[`ADCR_BIT_AUTO] &
                       (modeTrig[`ADCR_TRIG_HI:`ADCR_TRIG_LO] ==
                        `ADCR_SRC_FREE);
  assign convStart   = (swStart | autoStart) & ~busy | freeRestart;
  // register fields passed straight to the converter core; done irq level is done flag and irq enable
  assign convEnable  = ctrlA[`ADCR_BIT_ENABLE];
  assign bipolarMode = modeTrig[`ADCR_BIT_BIPOLAR];
  assign polarityRev = modeTrig[`ADCR_BIT_POL_REV];
  assign compMuxEn   = modeTrig[`ADCR_BIT_CMP_MUX];
  assign channelSel  = chanSel[`ADCR_CHAN_HI:`ADCR_CHAN_LO];
  assign prescaleSel = ctrlA[`ADCR_PRE_HI:`ADCR_PRE_LO];
  assign convDoneIrq = ctrlA[`ADCR_BIT_DONE] & ctrlA[`ADCR_BIT_IRQ_EN];

  // done flag: set on completion, cleared by vector or written one
  assign doneSet = convDone & busy;
  assign doneClr = irqVectorAck | (wrCtrlA & wb_dat_i[`ADCR_BIT_DONE]);

  // plain software registers; writes need byte lane 0
  always @(posedge core_clk) begin
    if (rst) begin
      // every software register starts at zero
      modeTrig   <= `ADCR_RST_BYTE;
      chanSel    <= `ADCR_RST_BYTE;
      pinDisable <= `ADCR_RST_BYTE;
    end else begin
      // mode register, reserved bits held at zero
      if (isWrite(regIdx, `ADCR_IDX_MODE_TRIG, busReq, wb_we_i,
                  wrLane0)) begin
        modeTrig <= wb_dat_i[7:0] & `ADCR_MODE_TRIG_MASK;
      end
      // left adjust and channel bits
      if (isWrite(regIdx, `ADCR_IDX_CHAN_SEL, busReq, wb_we_i,
                  wrLane0)) begin
        chanSel <= wb_dat_i[7:0] & `ADCR_CHAN_SEL_MASK;
      end
      // pin buffer disables, unused bits held at zero
      if (isWrite(regIdx, `ADCR_IDX_PIN_DISABLE, busReq, wb_we_i,
                  wrLane0)) begin
        pinDisable <= wb_dat_i[7:0] & `ADCR_PIN_MASK;
      end
    end
  end

  // control a: enable, auto, interrupt enable, prescaler, done flag
  always @(posedge core_clk) begin
    if (rst) begin
      ctrlA <= `ADCR_RST_BYTE;
    end else begin
      // done bit is not stored by a write; a written one clears it
      if (wrCtrlA) begin
        ctrlA[`ADCR_BIT_ENABLE] <= wb_dat_i[`ADCR_BIT_ENABLE];
        ctrlA[`ADCR_BIT_AUTO]   <= wb_dat_i[`ADCR_BIT_AUTO];
        ctrlA[`ADCR_BIT_IRQ_EN] <= wb_dat_i[`ADCR_BIT_IRQ_EN];
        ctrlA[`ADCR_PRE_HI:`ADCR_PRE_LO] <=
          wb_dat_i[`ADCR_PRE_HI:`ADCR_PRE_LO];
      end
      // completion and clear in one cycle: the set wins
      if (doneSet) begin
        ctrlA[`ADCR_BIT_DONE] <= 1'b1;
      end else if (doneClr) begin
        ctrlA[`ADCR_BIT_DONE] <= 1'b0;
      end
      // stored start bit stays zero; reads show busy instead
      ctrlA[`ADCR_BIT_START] <= 1'b0;
    end
  end

  // busy: set by a start, cleared by completion or by disabling
  always @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (wrCtrlA & ~wb_dat_i[`ADCR_BIT_ENABLE]) begin
      busy <= 1'b0;                  // disabling aborts a conversion
    end else if (convStart) begin
      busy <= 1'b1;                  // a restart keeps it set
    end else if (convDone) begin
      busy <= 1'b0;
    end
  end

  // result pair with read lock; a completion during lock waits
  always @(posedge core_clk) begin
    if (rst) begin
      result      <= `ADCR_RST_RESULT;
      lowReadLock <= 1'b0;
      heldData    <= `ADCR_RST_RESULT;
      heldValid   <= 1'b0;
    end else begin
      // low read freezes, high read releases
      if (rdLow) begin
        lowReadLock <= 1'b1;
      end else if (rdHigh) begin
        lowReadLock <= 1'b0;
      end
      // a completion while frozen is parked until the high read
      if (doneSet & (lowReadLock | rdLow) & ~rdHigh) begin
        heldData  <= convData;
        heldValid <= 1'b1;
      end else if (doneSet) begin
        result    <= convData;
        heldValid <= 1'b0;
      end else if (heldValid & ~lowReadLock & ~rdLow) begin
        result    <= heldData;
        heldValid <= 1'b0;
      end
    end
  end

  // pin synchroniser and buffer gating
  // stage one may be metastable, so nothing else reads it
  always @(posedge core_clk) begin
    if (rst) begin
      pinSync1 <= 4'h0;
      pinSync2 <= 4'h0;
    end else begin
      pinSync1 <= pinRaw;
      pinSync2 <= pinSync1;
    end
  end
  // only the second stage is read; a disabled pin reads zero
  assign pinBufOff = pinDisable[`ADCR_PIN_HI:`ADCR_PIN_LO];
  assign pinValue  = pinSync2 & ~pinBufOff;

  // read multiplexer; unmapped indices read zero
  always @* begin
    next_rdByte = `ADCR_RST_BYTE;
    case (regIdx)
      `ADCR_IDX_MODE_TRIG:   next_rdByte = modeTrig;
      `ADCR_IDX_RES_LOW:     next_rdByte = lowByte;
      `ADCR_IDX_RES_HIGH:    next_rdByte = highByte;
      // control a shows busy in place of the start bit
      `ADCR_IDX_CONV_CTRL_A: next_rdByte = {ctrlA[`ADCR_BIT_ENABLE], busy,
                                            ctrlA[`ADCR_BIT_AUTO:0]};
      `ADCR_IDX_CHAN_SEL:    next_rdByte = chanSel;
      `ADCR_IDX_PIN_DISABLE: next_rdByte = pinDisable;
      // status: parked completion, freeze, busy
      `ADCR_IDX_STATUS:      next_rdByte = {5'h00, heldValid, lowReadLock,
                                            busy};
      default:               next_rdByte = `ADCR_RST_BYTE;
    endcase
  end

  // bus answer: ack one cycle after the taken edge, never two in a row
  always @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      // read data holds until the next read is taken
      if (busReq & ~wb_we_i) begin
        wb_dat_o <= {24'h000000, next_rdByte};
      end
    end
  end
endmodule // adcr_top
`default_nettype wire

//--- sim/adcr_top_props.sv
// port-level checker for the adcr register block
// assumes binding onto adcr_top; single clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module adcr_top_props (
  input wire logic        core_clk,    // system clock
  input wire logic        rst,         // sync reset
  input wire logic        wb_cyc_i,    // bus cycle
  input wire logic        wb_stb_i,    // strobe
  input wire logic        wb_we_i,     // write enable
  input wire logic [5:0]  wb_adr_i,    // byte address
  input wire logic [31:0] wb_dat_o,    // read data
  input wire logic        wb_ack_o,    // acknowledge
  input wire logic        convDone,    // core completion
  input wire logic        irqVectorAck, // vector entry
  input wire logic        convDoneIrq, // done level
  input wire logic        bipolarMode, // mode level
  input wire logic        polarityRev, // swap level
  input wire logic [3:0]  pinBufOff,   // buffer off
  input wire logic [3:0]  pinValue     // gated pins
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // request answered exactly one cycle later
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o)
    else $error("ack missing after request");
  // ack is a single pulse
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pin_gate_a: assert property ((pinValue & pinBufOff) == 4'h0)
    else $error("disabled pin reads nonzero");
  resv_read_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[5:2] == 4'h3 |-> wb_dat_o[4:3] == 2'h0)
    else $error("reserved mode bits read nonzero");
  done_clear_a: assert property (irqVectorAck && !convDone |=>
    !convDoneIrq)
    else $error("vector entry left done flag");
  done_rise_a: assert property ($rose(convDoneIrq) |->
    $past(convDone) || (wb_ack_o && wb_we_i))
    else $error("done level rose without cause");
  mode_write_a: assert property (
    $changed({bipolarMode, polarityRev}) |->
    wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h3)
    else $error("mode bits changed without write");
  pinoff_write_a: assert property ($changed(pinBufOff) |->
    wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h8)
    else $error("pin disable changed without write");
endmodule // adcr_top_props
bind adcr_top adcr_top_props u_props (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .convDone(convDone), .irqVectorAck(irqVectorAck),
  .convDoneIrq(convDoneIrq), .bipolarMode(bipolarMode),
  .polarityRev(polarityRev), .pinBufOff(pinBufOff), .pinValue(pinValue)
);
`default_nettype wire

//--- sim/tb_adcr_top.sv
// register-level testbench for the adcr block
// assumes wishbone answers one cycle after a taken request
`timescale 1ns/10ps
`default_nettype none
module tb_adcr_top;
  logic        core_clk, rst, cyc, stb, we;  // clock, reset, bus controls
  logic        convDone, irqAck;             // core pulses
  logic [5:0]  adr, flags;                   // address, trigger flags
  logic [31:0] wdat;                         // write data
  logic [9:0]  convData;                     // core result
  logic [3:0]  pinRaw;                       // pin levels
  wire  [31:0] rdat;                         // read data
  wire         ack, convStart, doneIrq, bip, rev; // design outputs
  wire  [3:0]  pinBufOff, pinValue;          // pin outputs
  wire         en, cmux;                     // enable, comparator mux
  wire  [3:0]  chan;                         // channel select
  wire  [2:0]  pre;                          // prescaler select
  logic [3:0]  sel, lanes;                   // byte lanes, lane choice
  int          failures = 0, nCompared = 0, nStart = 0, s0 = 0; // tallies
  adcr_top dut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .convStart(convStart),
    .convDone(convDone), .convData(convData), .convEnable(en),
    .bipolarMode(bip), .polarityRev(rev), .compMuxEn(cmux),
    .channelSel(chan), .prescaleSel(pre), .convDoneIrq(doneIrq),
    .irqVectorAck(irqAck),
    .flagComp(flags[0]), .flagExt0(flags[1]), .flagT0CmpA(flags[2]),
    .flagT0Ovf(flags[3]), .flagT0CmpB(flags[4]), .flagPinChg(flags[5]),
    .pinRaw(pinRaw), .pinBufOff(pinBufOff), .pinValue(pinValue)
  );
  // free-running 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // count conversion starts
  always @(posedge core_clk) if (convStart === 1'b1) nStart <= nStart + 1;
  // compare and tally
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, i, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // core completion pulse with a result
  task automatic conv(input logic [9:0] d);
    @(posedge core_clk);
    convDone <= 1'b1;
    convData <= d;
    @(posedge core_clk);
    convDone <= 1'b0;
  endtask
  // starts seen since the last call
  task automatic starts(input int e);
    repeat (4) @(posedge core_clk);
    chk(nStart - s0, e);
    s0 = nStart;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run;
  end
  // main sequence
  initial begin
    {rst, cyc, stb, we, convDone, irqAck} = 6'h20;
    {adr, flags, wdat, convData} = '0;
    sel = 4'h0;
    lanes = 4'hf;
    pinRaw = 4'hf;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    lanes = 4'h0;
    wr(4'h3, 8'hff);
    lanes = 4'hf;
    rd(4'h3, 8'h00);
    $display("reset test done");
    wr(4'h3, 8'hff);
    rd(4'h3, 8'he7);
    chk({bip, rev, cmux}, 3'h7);
    wr(4'h3, 8'h00);
    chk({bip, rev, cmux}, 3'h0);
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h2f);
    chk(chan, 4'hf);
    wr(4'h7, 8'h00);
    $display("mode test done");
    wr(4'h6, 8'hc0);
    conv(10'h2a5);
    rd(4'h6, 8'h90);
    rd(4'h4, 8'ha5);
    rd(4'h5, 8'h02);
    wr(4'h7, 8'h20);
    rd(4'h4, 8'h40);
    wr(4'h6, 8'hc0);
    conv(10'h155);
    rd(4'h9, 8'h06);
    rd(4'h5, 8'ha9);
    rd(4'h4, 8'h40);
    rd(4'h5, 8'h55);
    $display("result test done");
    wr(4'h6, 8'h98);
    rd(4'h6, 8'h88);
    wr(4'h6, 8'hc8);
    conv(10'h000);
    @(posedge core_clk);
    chk(doneIrq, 1'b1);
    irqAck <= 1'b1;
    @(posedge core_clk);
    irqAck <= 1'b0;
    @(posedge core_clk);
    chk(doneIrq, 1'b0);
    $display("flag test done");
    chk(pinValue, 4'hf);
    wr(4'h8, 8'h14);
    repeat (3) @(posedge core_clk);
    chk({pinBufOff, pinValue}, 8'h5a);
    rd(4'h8, 8'h14);
    $display("pin test done");
    wr(4'h6, 8'h80);
    chk({en, pre}, 4'h8);
    wr(4'h3, 8'h01);
    s0 = nStart;
    flags <= 6'h01;
    starts(0);
    flags <= 6'h00;
    wr(4'h6, 8'ha0);
    for (int c = 1; c < 7; c++) begin
      wr(4'h3, c[7:0]);
      flags <= 6'h01 << (c - 1);
      starts(1);
      flags <= 6'h00;
      conv(10'h000);
    end
    wr(4'h3, 8'h01);
    flags <= 6'h02;
    wr(4'h3, 8'h02);
    starts(1);
    conv(10'h000);
    flags <= 6'h00;
    wr(4'h3, 8'h00);
    starts(0);
    wr(4'h6, 8'he0);
    conv(10'h000);
    starts(2);
    wr(4'h6, 8'h87);
    chk({en, pre}, 4'hf);
    wr(4'h6, 8'h00);
    chk({en, pre}, 4'h0);
    $display("trigger test done");
    complete_run;
  end
endmodule // tb_adcr_top
`default_nettype wire
